//--- hw/qdc_pkg.sv
// Shared constants for the quad converter serial control block.
package qdc_pkg;

	// Word and channel shape
	localparam int unsigned WORD_BITS = 24;
	localparam int unsigned DATA_BITS = 16;
	localparam int unsigned CHANNELS  = 4;
	localparam int unsigned PIN_COUNT = 10;
	localparam logic [4:0]  FRAME_BITS = 5'h18;
	localparam logic [4:0]  CNT_MAX    = 5'h1F;

	// Command word fields
	localparam int unsigned F_READ   = 23;
	localparam int unsigned F_SEL_HI = 22;
	localparam int unsigned F_SEL_LO = 20;
	localparam int unsigned F_CH_HI  = 17;
	localparam int unsigned F_CH_LO  = 16;
	localparam logic [2:0]  SEL_DATA = 3'h0;
	localparam logic [2:0]  SEL_CTRL = 3'h1;

	// Control word bit positions
	localparam int unsigned CTL_DAISY  = 0;
	localparam int unsigned CTL_DIR_LO = 2;
	localparam int unsigned CTL_OUT_LO = 4;

	// Codes and reset values
	localparam logic [15:0] CLEAR_CODE = 16'h0000;
	localparam logic [15:0] MID_CODE   = 16'h8000;
	localparam logic [15:0] SIGN_FLIP  = 16'h8000;
	localparam logic [9:0]  PIN_IDLE   = 10'h3FF;
	localparam logic [1:0]  DIR_RESET  = 2'h0;
	localparam logic [1:0]  OUT_RESET  = 2'h3;

	// Serial clock limits
	localparam int unsigned CLK_MHZ      = 100;
	localparam int unsigned SCLK_MAX_MHZ = 30;

endpackage

//--- hw/qdc_word_if.sv
// Valid/ready carrier for captured serial words between internal modules.
interface qdc_word_if;
	logic        valid;
	logic        ready;
	logic [23:0] data;

	modport prod (output valid, output data, input ready);
	modport cons (input valid, input data, output ready);
endinterface

//--- hw/qdc_word_buf.sv
// Two-entry word buffer between frame capture and register update.
module qdc_word_buf (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Filling and draining sides
	qdc_word_if.cons  in_if,
	qdc_word_if.prod  out_if
);

	logic [1:0][23:0] mem_reg;
	logic             wr_ptr_reg;
	logic             rd_ptr_reg;
	logic [1:0]       fill_reg;
	wire              push;
	wire              pop;

	assign in_if.ready  = (fill_reg != 2'h2);
	assign out_if.valid = (fill_reg != 2'h0);
	assign out_if.data  = mem_reg[rd_ptr_reg];
	assign push         = in_if.valid & in_if.ready;
	assign pop          = out_if.valid & out_if.ready;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_reg    <= '0;
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			fill_reg   <= 2'h0;
		end else begin
			if (push) begin
				mem_reg[wr_ptr_reg] <= in_if.data;
				wr_ptr_reg          <= ~wr_ptr_reg;
			end
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			fill_reg <= fill_reg + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule

//--- hw/qdc_top.sv
// Serial control logic of a quad 16-bit voltage-output converter.

////////////////////////////////////////////////////////////////////////////////
module qdc_top (
	// Clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         rst_n_i,
	// Serial port
	input  wire logic                         sclk_i,
	input  wire logic                         sync_n_i,
	input  wire logic                         serial_in_i,
	output logic                              serial_out_o,
	// Control pins
	input  wire logic                         clear_n_i,
	input  wire logic                         load_strobe_n_i,
	input  wire logic                         reset_in_n_i,
	input  wire logic                         coding_select_i,
	input  wire logic                         monitor_ok_i,
	output logic                              monitor_reset_out_o,
	// Digital I/O port
	input  wire logic [1:0]                   io_bit_i,
	output logic      [1:0]                   io_bit_o,
	output logic      [1:0]                   io_bit_oe_n_o,
	// Converter codes, offset binary toward the analog stage
	output logic      [qdc_pkg::CHANNELS-1:0][15:0] dac_drive_o
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [9:0] pin_s1_reg;
	logic [9:0] pin_s2_reg;
	logic       sclk_q_reg;
	logic       sync_q_reg;
	logic       load_q_reg;
	wire  [9:0] pin_raw;

	assign pin_raw = {io_bit_i, monitor_ok_i, coding_select_i, reset_in_n_i,
		load_strobe_n_i, clear_n_i, serial_in_i, sync_n_i, sclk_i};

	// Idle-high reset value mirrors the pin pull-ups, so nothing fires at release
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_s1_reg <= qdc_pkg::PIN_IDLE;
			pin_s2_reg <= qdc_pkg::PIN_IDLE;
			sclk_q_reg <= 1'b1;
			sync_q_reg <= 1'b1;
			load_q_reg <= 1'b1;
		end else begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
			sclk_q_reg <= pin_s2_reg[0];
			sync_q_reg <= pin_s2_reg[1];
			load_q_reg <= pin_s2_reg[4];
		end
	end

	wire       sclk_s    = pin_s2_reg[0];
	wire       sync_s    = pin_s2_reg[1];
	wire       sin_s     = pin_s2_reg[2];
	wire       clear_s   = pin_s2_reg[3];
	wire       load_s    = pin_s2_reg[4];
	wire       reset_in_n_s   = pin_s2_reg[5];
	wire       coding_s  = pin_s2_reg[6];
	wire       mon_s     = pin_s2_reg[7];
	wire [1:0] io_s      = pin_s2_reg[9:8];

	// Edges are found by sampling; each serial clock phase must span two clk periods,
	// which caps the usable rate below the port's nominal maximum at this clk.
	wire sclk_fall = sclk_q_reg & ~sclk_s;
	wire sclk_rise = ~sclk_q_reg & sclk_s;
	wire sync_rise = ~sync_q_reg & sync_s;
	wire load_fall = load_q_reg & ~load_s;
	wire hard_ok   = reset_in_n_s & mon_s;

	////////////////////////////////////////////////////////////////////////////
	// Frame capture and serial output

	logic [23:0] shift_reg;
	logic [4:0]  cnt_reg;
	logic        sout_reg;
	logic        rb_armed_reg;
	logic        daisy_reg;
	logic [1:0]  dir_reg;
	logic [1:0]  out_reg;
	logic        mon_reg;
	// Per-channel registers live in the generate loop; these nets gather them
	wire  [qdc_pkg::CHANNELS-1:0][15:0] dac_code;
	wire  [qdc_pkg::CHANNELS-1:0][15:0] drive_all;

	wire        frame_ok  = daisy_reg ? (cnt_reg >= qdc_pkg::FRAME_BITS)
	                                  : (cnt_reg == qdc_pkg::FRAME_BITS);
	wire        word_done = sync_rise & frame_ok;
	wire        is_read   = shift_reg[qdc_pkg::F_READ];
	wire [2:0]  cmd_sel   = shift_reg[qdc_pkg::F_SEL_HI:qdc_pkg::F_SEL_LO];
	wire [1:0]  cmd_ch    = shift_reg[qdc_pkg::F_CH_HI:qdc_pkg::F_CH_LO];
	wire [15:0] ctrl_view = {8'h00, io_s, out_reg, dir_reg, 1'b0, daisy_reg};
	wire [15:0] rb_value  = (cmd_sel == qdc_pkg::SEL_CTRL) ? ctrl_view : dac_code[cmd_ch];
	wire [23:0] rb_word   = {1'b0, cmd_sel, 2'b00, cmd_ch, rb_value};
	wire        sout_en   = daisy_reg | rb_armed_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_reg    <= '0;
			cnt_reg      <= 5'h00;
			sout_reg     <= 1'b0;
			rb_armed_reg <= 1'b0;
		end else begin
			if (word_done && is_read) begin
				shift_reg    <= rb_word;
				sout_reg     <= rb_word[23];
				rb_armed_reg <= 1'b1;
			end else if (sync_rise) begin
				rb_armed_reg <= 1'b0;
			end else if (!sync_s && sclk_fall) begin
				shift_reg <= {shift_reg[22:0], sin_s};
				if (cnt_reg != qdc_pkg::CNT_MAX)
					cnt_reg <= cnt_reg + 5'h01;
			end else if (!sync_s && sclk_rise) begin
				sout_reg <= sout_en & shift_reg[23];
			end
			if (sync_s)
				cnt_reg <= 5'h00;
		end
	end

	assign serial_out_o = sout_reg;

	////////////////////////////////////////////////////////////////////////////
	// Word buffer

	qdc_word_if cap_if ();
	qdc_word_if upd_if ();

	// A word finished while both entries are full is dropped
	assign cap_if.valid = word_done & ~is_read;
	assign cap_if.data  = shift_reg;
	// Updates stall during clear or reset so buffered words apply afterwards
	assign upd_if.ready = clear_s & hard_ok;

	qdc_word_buf u_buf (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.in_if   (cap_if),
		.out_if  (upd_if)
	);

	wire        upd_go   = upd_if.valid & upd_if.ready;
	wire [2:0]  upd_sel  = upd_if.data[qdc_pkg::F_SEL_HI:qdc_pkg::F_SEL_LO];
	wire [1:0]  upd_ch   = upd_if.data[qdc_pkg::F_CH_HI:qdc_pkg::F_CH_LO];
	wire [15:0] upd_val  = upd_if.data[15:0];
	wire        data_wr  = upd_go & (upd_sel == qdc_pkg::SEL_DATA);
	wire        ctrl_wr  = upd_go & (upd_sel == qdc_pkg::SEL_CTRL);

	////////////////////////////////////////////////////////////////////////////
	// Control, I/O port and monitor

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			daisy_reg <= 1'b0;
			dir_reg   <= qdc_pkg::DIR_RESET;
			out_reg   <= qdc_pkg::OUT_RESET;
			mon_reg   <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				daisy_reg <= upd_val[qdc_pkg::CTL_DAISY];
				dir_reg   <= upd_val[qdc_pkg::CTL_DIR_LO +: 2];
				out_reg   <= upd_val[qdc_pkg::CTL_OUT_LO +: 2];
			end
			mon_reg <= mon_s;
		end
	end

	// Released pins rely on the pad's weak pull-up to read high
	assign io_bit_o            = out_reg;
	assign io_bit_oe_n_o       = ~dir_reg;
	assign monitor_reset_out_o = mon_reg;

	////////////////////////////////////////////////////////////////////////////
	// Channel registers

	// Reset to 0 V: mid code in offset binary, zero in twos complement
	wire [15:0] reset_code = coding_s ? qdc_pkg::MID_CODE : qdc_pkg::CLEAR_CODE;
	wire [15:0] drive_flip = coding_s ? 16'h0000 : qdc_pkg::SIGN_FLIP;

	for (genvar c = 0; c < qdc_pkg::CHANNELS; c++) begin : g_ch
		logic [15:0] input_reg;
		logic [15:0] code_reg;
		logic        pend_reg;
		logic [15:0] drive_reg;
		wire         wr_hit = data_wr & (upd_ch == 2'(c));

		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				input_reg <= qdc_pkg::CLEAR_CODE;
				code_reg  <= qdc_pkg::CLEAR_CODE;
				pend_reg  <= 1'b0;
				drive_reg <= qdc_pkg::MID_CODE;
			end else begin
				if (!hard_ok) begin
					code_reg <= reset_code;
					pend_reg <= 1'b0;
				end else if (!clear_s) begin
					code_reg <= qdc_pkg::CLEAR_CODE;
					pend_reg <= 1'b0;
				end else if (wr_hit) begin
					input_reg <= upd_val;
					if (!load_s) begin
						code_reg <= upd_val;
						pend_reg <= 1'b0;
					end else begin
						pend_reg <= 1'b1;
					end
				end else if (load_fall && pend_reg) begin
					code_reg <= input_reg;
					pend_reg <= 1'b0;
				end
				drive_reg <= code_reg ^ drive_flip;
			end
		end

		assign dac_code[c]  = code_reg;
		assign drive_all[c] = drive_reg;
	end

	assign dac_drive_o = drive_all;

endmodule

//--- test/qdc_host_model.sv
// Serial host model that frames words onto the converter's serial port.
module qdc_host_model (
	// Clock
	input  wire logic clk_i,
	// Serial pins
	input  wire logic ser_out_i,
	output logic      sclk_o   = 1'b1,
	output logic      sync_n_o = 1'b1,
	output logic      ser_in_o = 1'b1
);
	timeunit 1ns;
	timeprecision 1ps;

	// 80 ns serial clock, kept below the 30 MHz ceiling
	localparam int HALF = 4;
	logic [23:0] rd = 24'h0;

	////////////////////////////////////////
	// Sends the top n bits of w, MSB first; the clock stands still between frames
	task automatic send(input logic [23:0] w, input int n);
		sync_n_o <= 1'b0;
		repeat (HALF) @(posedge clk_i);
		for (int i = 23; i > 23 - n; i--) begin
			ser_in_o <= w[i];
			repeat (HALF) @(posedge clk_i);
			sclk_o <= 1'b0;
			repeat (HALF) @(posedge clk_i);
			// Read late in the low phase, well after the last rising edge moved it
			rd <= {rd[22:0], ser_out_i};
			sclk_o <= 1'b1;
		end
		repeat (HALF) @(posedge clk_i);
		sync_n_o <= 1'b1;
		ser_in_o <= 1'b1;
		repeat (HALF) @(posedge clk_i);
	endtask
endmodule

//--- test/qdc_top_asserts.sv
// Port-level assertions of the quad converter serial control block.
module qdc_top_asserts (
	// Clock and reset
	input wire logic                                clk_i,
	input wire logic                                rst_n_i,
	// Observed pins
	input wire logic                                sclk_i,
	input wire logic                                sync_n_i,
	input wire logic                                serial_out_o,
	input wire logic                                clear_n_i,
	input wire logic                                load_strobe_n_i,
	input wire logic                                reset_in_n_i,
	input wire logic                                coding_select_i,
	input wire logic                                monitor_ok_i,
	input wire logic                                monitor_reset_out_o,
	input wire logic [1:0]                          io_bit_o,
	input wire logic [1:0]                          io_bit_oe_n_o,
	input wire logic [qdc_pkg::CHANNELS-1:0][15:0] dac_drive_o
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Cycles since a control or serial pin last moved; outputs may only follow a cause
	wire  [5:0] ctl = {sync_n_i, load_strobe_n_i, clear_n_i, reset_in_n_i, coding_select_i,
		monitor_ok_i};
	logic [3:0] calm_reg;
	logic [3:0] ser_calm_reg;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			calm_reg     <= 4'h0;
			ser_calm_reg <= 4'h0;
		end else begin
			calm_reg     <= $changed(ctl) ? 4'h0 : calm_reg + {3'h0, calm_reg != 4'hF};
			ser_calm_reg <= $changed({sclk_i, sync_n_i}) ? 4'h0 :
				ser_calm_reg + {3'h0, ser_calm_reg != 4'hF};
		end
	end

	a_clear_zero: assert property (
		(!clear_n_i && reset_in_n_i && monitor_ok_i && coding_select_i) [*8]
		|-> dac_drive_o == '0) else $error("clear left a code");
	a_clear_twos: assert property (
		(!clear_n_i && reset_in_n_i && monitor_ok_i && !coding_select_i) [*8]
		|-> dac_drive_o == {4{16'h8000}}) else $error("twos clear not mid");
	a_reset_mid: assert property (
		(!reset_in_n_i) [*8] |-> dac_drive_o == {4{16'h8000}}) else $error("reset not mid");
	a_monitor_mid: assert property (
		(!monitor_ok_i) [*8] |-> dac_drive_o == {4{16'h8000}}) else $error("monitor not mid");
	a_monitor_copy: assert property (
		$past(rst_n_i, 4) |-> monitor_reset_out_o == $past(monitor_ok_i, 3))
		else $error("monitor output lag");
	a_pins_reset: assert property (
		$rose(rst_n_i) |-> io_bit_oe_n_o == 2'h3 && io_bit_o == 2'h3 && !serial_out_o)
		else $error("pin reset state");
	a_drive_cause: assert property (
		$changed(dac_drive_o) |-> calm_reg < 4'h8) else $error("code moved uncaused");
	a_serial_cause: assert property (
		$changed(serial_out_o) |-> ser_calm_reg < 4'h8) else $error("serial out uncaused");
endmodule

bind qdc_top qdc_top_asserts chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
	.sync_n_i(sync_n_i), .serial_out_o(serial_out_o), .clear_n_i(clear_n_i),
	.load_strobe_n_i(load_strobe_n_i), .reset_in_n_i(reset_in_n_i),
	.coding_select_i(coding_select_i), .monitor_ok_i(monitor_ok_i),
	.monitor_reset_out_o(monitor_reset_out_o), .io_bit_o(io_bit_o),
	.io_bit_oe_n_o(io_bit_oe_n_o), .dac_drive_o(dac_drive_o));

//--- test/quad_dac_serial_control_test.sv
// Self-checking bench of the quad converter serial control block.
module quad_dac_serial_control_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic            clk_i   = 1'b0;
	logic            rst_n_i = 1'b0;
	logic            clear_n = 1'b1;
	logic            load_n  = 1'b0;
	logic            rin_n   = 1'b1;
	logic            coding  = 1'b1;
	logic            mon_ok  = 1'b1;
	wire             sclk, sync_n, ser_in, ser_out, mon_out;
	wire [1:0]       io_o, io_oe_n;
	// Undriven I/O pins float up through their pull-ups
	wire [1:0]       io_pin = io_oe_n | io_o;
	wire [3:0][15:0] dac;
	int              miscompares = 0;
	int              n_checks = 0;

	qdc_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .sync_n_i(sync_n),
		.serial_in_i(ser_in), .serial_out_o(ser_out), .clear_n_i(clear_n),
		.load_strobe_n_i(load_n), .reset_in_n_i(rin_n), .coding_select_i(coding),
		.monitor_ok_i(mon_ok), .monitor_reset_out_o(mon_out), .io_bit_i(io_pin),
		.io_bit_o(io_o), .io_bit_oe_n_o(io_oe_n), .dac_drive_o(dac));
	qdc_host_model host_u (.clk_i(clk_i), .ser_out_i(ser_out), .sclk_o(sclk),
		.sync_n_o(sync_n), .ser_in_o(ser_in));

	////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wr(input logic [1:0] ch, input logic [15:0] v);
		host_u.send({6'h00, ch, v}, 24);
		cyc(4);
	endtask
	task automatic summarize();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	////////////////////////////////////////
	task automatic t_direct();
		for (int k = 0; k < 4; k++)
			wr(k[1:0], 16'hA5F0 + 16'(k));
		// One bit short: must be ignored
		host_u.send(24'h001234, 23);
		cyc(8);
		for (int k = 0; k < 4; k++)
			chk(dac[k], 16'hA5F0 + 16'(k));
	endtask
	task automatic t_sim();
		load_n <= 1'b1;
		for (int k = 0; k < 4; k++)
			wr(k[1:0], 16'h1100 * 16'(k + 1));
		for (int k = 0; k < 4; k++)
			chk(dac[k], 16'hA5F0 + 16'(k));
		load_n <= 1'b0;
		cyc(8);
		chk(dac, 64'h4400_3300_2200_1100);
	endtask
	task automatic t_clear();
		clear_n <= 1'b0;
		cyc(8);
		chk(dac, 64'h0);
		// Buffer stalls under clear: two words wait, the third is refused
		wr(2'h0, 16'h0A0A);
		wr(2'h1, 16'h0B0B);
		wr(2'h2, 16'h0C0C);
		chk(dac, 64'h0);
		clear_n <= 1'b1;
		cyc(12);
		chk(dac, 64'h0000_0000_0B0B_0A0A);
	endtask
	task automatic t_codes();
		coding <= 1'b0;
		cyc(8);
		chk(dac, 64'h8000_8000_8B0B_8A0A);
		clear_n <= 1'b0;
		cyc(10);
		chk(dac, {4{16'h8000}});
		clear_n <= 1'b1;
		coding <= 1'b1;
		wr(2'h3, 16'h7777);
		rin_n <= 1'b0;
		cyc(10);
		chk(dac, {4{16'h8000}});
		rin_n <= 1'b1;
		mon_ok <= 1'b0;
		cyc(10);
		chk(mon_out, 64'h0);
		mon_ok <= 1'b1;
		cyc(8);
		chk(mon_out, 64'h1);
		chk(dac, {4{16'h8000}});
	endtask
	task automatic t_io();
		host_u.send(24'h10002C, 24);
		cyc(8);
		chk({io_oe_n, io_o}, 64'h2);
		host_u.send(24'h900000, 24);
		host_u.send(24'h900000, 24);
		chk(host_u.rd, 64'h1000AC);
		// Daisy chain: the following frame pushes the previous word out unchanged
		host_u.send(24'h10002D, 24);
		host_u.send(24'h021357, 24);
		host_u.send(24'h10002C, 24);
		chk(host_u.rd, 64'h021357);
		chk(dac[2], 64'h1357);
		// Channel readback returns the held reset code of channel 3
		host_u.send(24'h830000, 24);
		host_u.send(24'h830000, 24);
		chk(host_u.rd, 64'h038000);
	endtask

	////////////////////////////////////////
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		cyc(16);
		rst_n_i <= 1'b1;
		cyc(4);
		t_direct();
		t_sim();
		t_clear();
		t_codes();
		t_io();
		summarize();
	end
	initial begin
		#300us;
		miscompares++;
		summarize();
	end
endmodule
